// file: pkg/dsc_defs.svh
// Constants for the disk security command handler: opcodes, flag bits, word layout, timing.
// Assumes inclusion by bare name from the package and both end modules.
// Notes on behaviour
// R1: Recalibrate opcode 1x moves heads to cylinder zero
// R2: Cylinder zero unreachable sets track-zero-missing, error
// R3: Disable-password takes exactly one host sector
// R4: Sector: control word, 16 password words, reserved
// R5: Selector bit picks user or master comparison
// R6: Disable on match, master password kept
// R7: Host issues disable-password only when unlocked; dsc_host issues it in any state and the device never checks the locked state
// R8: Erase-prepare immediately precedes erase-unit, no data
// R9: Erase-prepare also precedes format-unit; the device aborts format-unit as an unknown opcode, prepared or not
// R10: Erase-unit without prior prepare is aborted
// R11: Erase-unit takes sector, mismatch aborts
// R12: Control bit 1 enhanced unsupported, rest reserved
// R13: Erase covers zero to native maximum address
// R14: Zeros written unverified, defect lists untouched
// R15: After erase lock disabled, master kept
// R16: Erase time reported in identify word 89
// R17: Freeze-lock enters frozen state at once
// R18: Frozen rejects set, unlock, disable, erase
// R19: Frozen survives resets, cleared only power off
// R20: User password enables lock, locks after reset
// R21: Master password only stored, never locks
// R22: Set-password takes one sector steering action
// R23: Control bit 8 level, bit 0 identifier
// R24: Rejections set aborted, error summary, clear busy
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_OP_RECAL_HI   4'h1
`define DSC_OP_SET_PW     8'hf1
`define DSC_OP_UNLOCK     8'hf2
`define DSC_OP_ERASE_PREP 8'hf3
`define DSC_OP_ERASE_UNIT 8'hf4
`define DSC_OP_FREEZE     8'hf5
`define DSC_OP_DISABLE_PW 8'hf6
`define DSC_OP_FORMAT     8'hf7
`define DSC_ERR_TRK0_BIT  1
`define DSC_ERR_ABORT_BIT 2
`define DSC_ST_ERR_BIT    0
`define DSC_ST_DRQ_BIT    3
`define DSC_ST_SEEK_BIT   4
`define DSC_ST_RDY_BIT    6
`define DSC_ST_BSY_BIT    7
`define DSC_CW_ID_BIT     0
`define DSC_CW_ENH_BIT    1
`define DSC_CW_LEVEL_BIT  8
`define DSC_PW_FIRST      8'h01
`define DSC_PW_LAST       8'h10
`define DSC_SECTOR_LAST   8'hff
`define DSC_ID_ERASE_WORD 89
`define DSC_STEP_NS       40
`define DSC_CLK_NS        4
`define DSC_STEP_CYC      ((`DSC_STEP_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_ST_RESET      8'h50
`endif

// file: pkg/dsc_pkg.sv
// Types shared by both ends of the security command link.
// Assumes dsc_defs.svh on the include path.
`include "dsc_defs.svh"
package dsc_pkg;
  typedef enum logic [2:0] {DSC_IDLE, DSC_RECAL, DSC_XFER, DSC_ERASE, DSC_DONE} dsc_dev_state_t;
  typedef enum logic [1:0] {DSC_H_IDLE, DSC_H_WAIT, DSC_H_SEND, DSC_H_END} dsc_host_state_t;
endpackage

// file: pkg/dsc_if.sv
// Task-file link between host controller and drive security logic.
// Assumes one shared clock and reset supplied by the surrounding bench.
`timescale 1ns/100ps
`default_nettype none
interface dsc_if;
  logic        cmd_wr;
  logic [7:0]  opcode_port;
  logic [7:0]  drive_head_select;
  logic        data_wr;
  logic [15:0] data_word;
  logic [7:0]  error_flags;
  logic [7:0]  device_status_flags;
  modport dev (input cmd_wr, opcode_port, drive_head_select, data_wr, data_word,
               output error_flags, device_status_flags);
  modport host (output cmd_wr, opcode_port, drive_head_select, data_wr, data_word,
                input error_flags, device_status_flags);
endinterface
`default_nettype wire

// file: hw/dsc_device.sv
// Drive-side command execution for recalibrate and password security commands.
// Assumes host keeps the task-file protocol; media and heads are modelled as ports.
`timescale 1ns/100ps
`default_nettype none
`include "dsc_defs.svh"
module dsc_device
  import dsc_pkg::*;
#(
  parameter int ERASE_BLOCKS = 16,
  parameter logic [15:0] ERASE_MINUTES = 16'h0001
) (
  input  wire logic clk,              // 250 MHz clock
  input  wire logic rst,              // Async hard reset
  input  wire logic power_on,         // Power-on reset pulse, clears frozen
  dsc_if.dev        tf,               // Task file
  input  wire logic trk0_reached,     // Head at cylinder zero after a step
  output logic      head_step,        // Step pulse toward cylinder zero
  output logic      zero_wr,          // Zero write of one block
  output logic [31:0] zero_addr,      // Block being zeroed
  output logic [15:0] id_word89,      // Identify word 89
  output logic      lock_enabled,     // Lock function enabled
  output logic      locked,           // Device locked
  output logic      frozen            // Frozen state
);
  localparam int MAX_STEPS = 1024;
  typedef struct packed {
    dsc_dev_state_t st;
    logic [7:0]     op;
    logic [7:0]     err;
    logic [7:0]     sts;
    logic [7:0]     widx;
    logic [15:0]    cw;
    logic           mism;
    logic           prep;
    logic           lock_en;
    logic           lck;
    logic           frz;
    logic           maxlvl;
    logic [10:0]    steps;
    logic [7:0]     tick;
    logic [31:0]    addr;
    logic           relock;
    logic [2:0]     t0_sync;
    logic           t0;
    logic [15:0][15:0] upw;
    logic [15:0][15:0] mpw;
  } dsc_dev_t;
  dsc_dev_t s, next_s;

  function automatic logic guarded(input logic [7:0] op);
    return op == `DSC_OP_SET_PW || op == `DSC_OP_UNLOCK ||
           op == `DSC_OP_DISABLE_PW || op == `DSC_OP_ERASE_UNIT;
  endfunction

  function automatic logic [15:0] stored_word(input dsc_dev_t v, input logic [3:0] i);
    return v.cw[`DSC_CW_ID_BIT] ? v.mpw[i] : v.upw[i]; // R5
  endfunction

  logic [3:0] pw_i;
  assign pw_i = 4'(s.widx - `DSC_PW_FIRST);

  always_comb begin
    next_s = s;
    head_step = 1'b0;
    zero_wr = 1'b0;
    // Head sensor is asynchronous: three stages, taken when last two agree
    next_s.t0_sync = {s.t0_sync[1:0], trk0_reached};
    if (s.t0_sync[2] == s.t0_sync[1]) begin
      next_s.t0 = s.t0_sync[1];
    end
    if (tf.cmd_wr && s.st == DSC_IDLE) begin
      next_s.op = tf.opcode_port;
      next_s.err = 8'h00;
      next_s.sts = `DSC_ST_RESET | 8'h80;
      next_s.prep = (tf.opcode_port == `DSC_OP_ERASE_PREP); // R8 R10
      next_s.widx = 8'h00;
      next_s.mism = 1'b0;
      next_s.steps = 11'h000;
      if (tf.opcode_port[7:4] == `DSC_OP_RECAL_HI) begin
        next_s.st = DSC_RECAL; // R1
      end else if (s.frz && guarded(tf.opcode_port)) begin
        next_s.st = DSC_DONE; // R17 R18
        next_s.err[`DSC_ERR_ABORT_BIT] = 1'b1;
      end else if (tf.opcode_port == `DSC_OP_ERASE_UNIT && !s.prep) begin
        next_s.st = DSC_DONE; // R10
        next_s.err[`DSC_ERR_ABORT_BIT] = 1'b1;
      end else if (tf.opcode_port == `DSC_OP_SET_PW || tf.opcode_port == `DSC_OP_DISABLE_PW ||
                   tf.opcode_port == `DSC_OP_ERASE_UNIT) begin
        next_s.st = DSC_XFER; // R3 R11 R22
        next_s.sts[`DSC_ST_DRQ_BIT] = 1'b1;
        next_s.sts[`DSC_ST_BSY_BIT] = 1'b0;
      end else if (tf.opcode_port == `DSC_OP_FREEZE) begin
        next_s.frz = 1'b1; // R17
        next_s.st = DSC_DONE;
      end else if (tf.opcode_port == `DSC_OP_ERASE_PREP) begin
        next_s.st = DSC_DONE; // R8
      end else begin
        next_s.st = DSC_DONE;
        next_s.err[`DSC_ERR_ABORT_BIT] = 1'b1;
      end
    end else begin
      case (s.st)
        DSC_IDLE: begin
        end
        DSC_RECAL: begin
          next_s.tick = s.tick + 8'h01;
          if (s.tick == 8'(`DSC_STEP_CYC - 1)) begin
            next_s.tick = 8'h00;
            if (s.t0) begin
              next_s.st = DSC_DONE; // R1
            end else if (s.steps == 11'(MAX_STEPS)) begin
              next_s.err[`DSC_ERR_TRK0_BIT] = 1'b1; // R2
              next_s.st = DSC_DONE;
            end else begin
              head_step = 1'b1;
              next_s.steps = s.steps + 11'h001;
            end
          end
        end
        DSC_XFER: begin
          if (tf.data_wr) begin // R4
            next_s.widx = s.widx + 8'h01;
            if (s.widx == 8'h00) begin
              next_s.cw = tf.data_word;
            end else if (s.widx <= `DSC_PW_LAST) begin
              if (s.op == `DSC_OP_SET_PW) begin
                if (s.cw[`DSC_CW_ID_BIT]) next_s.mpw[pw_i] = tf.data_word; // R21
                else next_s.upw[pw_i] = tf.data_word; // R20
              end else if (tf.data_word != stored_word(s, pw_i)) begin
                next_s.mism = 1'b1; // R5
              end
            end
            if (s.widx == `DSC_SECTOR_LAST) begin
              next_s.sts[`DSC_ST_DRQ_BIT] = 1'b0;
              next_s.sts[`DSC_ST_BSY_BIT] = 1'b1;
              next_s.st = DSC_DONE;
              if (s.op == `DSC_OP_SET_PW) begin
                if (!s.cw[`DSC_CW_ID_BIT]) begin
                  next_s.lock_en = 1'b1; // R20 R23
                  next_s.maxlvl = s.cw[`DSC_CW_LEVEL_BIT];
                end
              end else if (s.op == `DSC_OP_ERASE_UNIT && s.cw[`DSC_CW_ENH_BIT]) begin
                next_s.err[`DSC_ERR_ABORT_BIT] = 1'b1; // R12
              end else if (s.mism) begin
                next_s.err[`DSC_ERR_ABORT_BIT] = 1'b1; // R11
              end else if (s.op == `DSC_OP_ERASE_UNIT) begin
                next_s.st = DSC_ERASE;
                next_s.addr = 32'h0; // R13
              end else begin
                next_s.lock_en = 1'b0; // R6
                next_s.lck = 1'b0;
              end
            end
          end
        end
        DSC_ERASE: begin
          zero_wr = 1'b1; // R14
          next_s.addr = s.addr + 32'h1;
          if (s.addr == 32'(ERASE_BLOCKS - 1)) begin
            next_s.lock_en = 1'b0; // R15
            next_s.lck = 1'b0;
            next_s.st = DSC_DONE;
          end
        end
        DSC_DONE: begin
          next_s.sts[`DSC_ST_BSY_BIT] = 1'b0; // R24
          next_s.sts[`DSC_ST_DRQ_BIT] = 1'b0;
          next_s.sts[`DSC_ST_ERR_BIT] = |s.err;
          next_s.st = DSC_IDLE;
        end
        default: next_s.st = DSC_IDLE;
      endcase
    end
    // Lock takes effect on the first cycle after any reset
    next_s.relock = 1'b0;
    if (power_on || s.relock) begin
      next_s.lck = s.lock_en; // R20 R21
    end
    if (power_on) begin
      next_s.frz = 1'b0; // R19
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s.st <= DSC_IDLE;
      s.op <= 8'h00;
      s.err <= 8'h00;
      s.sts <= `DSC_ST_RESET;
      s.widx <= 8'h00;
      s.cw <= 16'h0000;
      s.mism <= 1'b0;
      s.prep <= 1'b0;
      // Lock, frozen, level and passwords stay out of reset and persist
      s.relock <= 1'b1; // R20
      s.t0_sync <= 3'h0;
      s.t0 <= 1'b0;
      s.tick <= 8'h00;
      s.steps <= 11'h000;
      s.addr <= 32'h0;
    end else begin
      s <= next_s;
    end
  end

  assign tf.error_flags = s.err;
  assign tf.device_status_flags = s.sts;
  assign zero_addr = s.addr;
  assign id_word89 = ERASE_MINUTES; // R16
  assign lock_enabled = s.lock_en;
  assign locked = s.lck;
  assign frozen = s.frz;
endmodule
`default_nettype wire

// file: hw/dsc_host.sv
// Host-side controller issuing one security command with its password sector.
// Assumes the device on the same clock; software uses a plain register port.
`timescale 1ns/100ps
`default_nettype none
`include "dsc_defs.svh"
module dsc_host
  import dsc_pkg::*;
(
  input  wire logic        clk,      // 250 MHz clock
  input  wire logic        rst,      // Async reset
  dsc_if.host              tf,       // Task file
  input  wire logic [3:0]  addr,     // Register index
  input  wire logic [15:0] wdata,    // Write data
  input  wire logic        wr,       // Write strobe
  input  wire logic        rd,       // Read strobe
  output logic [15:0]      rdata     // Read data, one cycle later
);
  typedef struct packed {
    dsc_host_state_t st;
    logic [7:0]  op;
    logic [15:0] cw;
    logic [15:0][15:0] pw;
    logic [7:0]  idx;
    logic        cmd;
    logic        dwr;
    logic [15:0] dword;
    logic [15:0] rd_q;
  } dsc_host_s_t;
  dsc_host_s_t s, next_s;
  // Index 0 opcode go, 1 control word, 2..15 password; reads give error and status
  always_comb begin
    next_s = s;
    next_s.cmd = 1'b0;
    next_s.dwr = 1'b0;
    if (wr && addr == 4'h0 && s.st == DSC_H_IDLE) begin
      next_s.op = wdata[7:0];
      next_s.cmd = 1'b1; // R8 R9
      next_s.idx = 8'h00;
      next_s.st = DSC_H_WAIT;
    end else if (wr && addr == 4'h1) begin
      next_s.cw = wdata; // R23
    end else if (wr && addr >= 4'h2) begin
      next_s.pw[4'(addr - 4'h2)] = wdata;
    end
    next_s.rd_q = rd ? {tf.error_flags, tf.device_status_flags} : 16'h0000;
    case (s.st)
      DSC_H_IDLE: begin
      end
      DSC_H_WAIT: begin
        if (tf.device_status_flags[`DSC_ST_DRQ_BIT]) next_s.st = DSC_H_SEND; // R3 R22
        else if (!tf.device_status_flags[`DSC_ST_BSY_BIT] && !s.cmd) next_s.st = DSC_H_IDLE;
      end
      DSC_H_SEND: begin
        next_s.dwr = 1'b1; // R4
        next_s.dword = (s.idx == 8'h00) ? s.cw :
                       (s.idx <= `DSC_PW_LAST) ? s.pw[4'(s.idx - `DSC_PW_FIRST)] : 16'h0000;
        next_s.idx = s.idx + 8'h01;
        if (s.idx == `DSC_SECTOR_LAST) next_s.st = DSC_H_END;
      end
      DSC_H_END: next_s.st = DSC_H_WAIT;
      default: next_s.st = DSC_H_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s.st <= DSC_H_IDLE;
      s.op <= 8'h00;
      s.cw <= 16'h0000;
      s.idx <= 8'h00;
      s.cmd <= 1'b0;
      s.dwr <= 1'b0;
      s.dword <= 16'h0000;
      s.rd_q <= 16'h0000;
      s.pw <= 256'h0;
    end else begin
      s <= next_s;
    end
  end
  assign tf.cmd_wr = s.cmd;
  assign tf.opcode_port = s.op;
  assign tf.drive_head_select = 8'ha0;
  assign tf.data_wr = s.dwr;
  assign tf.data_word = s.dword;
  assign rdata = s.rd_q;
endmodule
`default_nettype wire

// file: sim/dsc_checker.sv
// Assertions on the task-file link between host and device ends.
// Assumes one clock and an async active-high reset shared by both ends.
`timescale 1ns/100ps
`default_nettype none
module dsc_checker (
  input wire logic        clk,                 // Clock
  input wire logic        rst,                 // Async reset
  input wire logic        cmd_wr,              // Command pulse
  input wire logic [7:0]  opcode_port,         // Opcode
  input wire logic [7:0]  drive_head_select,   // Device select
  input wire logic        data_wr,             // Data word strobe
  input wire logic [15:0] data_word,           // Data word
  input wire logic [7:0]  error_flags,         // Error flags
  input wire logic [7:0]  device_status_flags  // Status flags
);
  logic [7:0] st;
  logic [7:0] er;
  logic       idle;
  logic [8:0] n_words;
  assign st   = device_status_flags;
  assign er   = error_flags;
  assign idle = !st[7] && !st[3];
  // Words handed over since the last command
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      n_words <= 9'h000;
    else if (cmd_wr)
      n_words <= 9'h000;
    else if (data_wr)
      n_words <= n_words + 9'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  abort_summary_a: assert property (!st[7] && er[2] |-> st[0])
    else $error("abort without error summary");
  trk0_summary_a: assert property (!st[7] && er[1] |-> st[0])
    else $error("track zero flag without error summary");
  drq_cause_a: assert property ($rose(st[3]) |-> $past(cmd_wr) &&
    $past(opcode_port) inside {8'hf1, 8'hf2, 8'hf4, 8'hf6})
    else $error("transfer request without data command");
  prep_nodata_a: assert property (cmd_wr && opcode_port == 8'hf3 |=> !st[3] [*2])
    else $error("erase prepare asked for data");
  freeze_quick_a: assert property (idle && cmd_wr && opcode_port == 8'hf5
    |-> ##[1:3] (!st[7] && !st[3] && !er[2]))
    else $error("freeze did not end at once");
  word_in_drq_a: assert property (data_wr |-> st[3])
    else $error("data word outside transfer request");
  sector_len_a: assert property (n_words <= 9'h100)
    else $error("more than one sector sent");
  data_cmd_a: assert property (idle && cmd_wr && opcode_port inside {8'hf1, 8'hf6}
    |-> ##[1:3] (st[3] || er[2]))
    else $error("set or disable got no transfer request");
  pad_zero_a: assert property (data_wr && n_words > 9'h010 |-> data_word == 16'h0000)
    else $error("reserved sector word not zero");
endmodule
`default_nettype wire

// file: sim/tb.sv
// Testbench: host and device ends joined by the task-file interface.
// Assumes the design package, interface and checker compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] cw;
    logic [1:0]  sel;
    logic        ab;
    logic        le;
  } dsc_row_t;
  logic        clk, rst, power_on, trk0_reached, allow, wr, rd;
  logic        head_step, zero_wr, lock_enabled, locked, frozen;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, d, id_word89;
  logic [31:0] zero_addr;
  int          n_errors, n_tests, steps, blk, k;
  logic [7:0]  fz [4] = '{8'hf1, 8'hf2, 8'hf6, 8'hf4};
  dsc_row_t    rows [16] = '{
    '{8'hf1, 16'h0000, 2'd0, 1'b0, 1'b1},
    '{8'hf1, 16'h0001, 2'd2, 1'b0, 1'b1},
    '{8'hf6, 16'h0000, 2'd1, 1'b1, 1'b1},
    '{8'hf6, 16'h0001, 2'd0, 1'b1, 1'b1},
    '{8'hf6, 16'h0000, 2'd0, 1'b0, 1'b0},
    '{8'hf4, 16'h0000, 2'd0, 1'b1, 1'b0},
    '{8'hf1, 16'h0000, 2'd0, 1'b0, 1'b1},
    '{8'hf3, 16'h0000, 2'd0, 1'b0, 1'b1},
    '{8'hf4, 16'h0000, 2'd1, 1'b1, 1'b1},
    '{8'hf3, 16'h0000, 2'd0, 1'b0, 1'b1},
    '{8'hf4, 16'h0002, 2'd0, 1'b1, 1'b1},
    '{8'hf3, 16'h0000, 2'd0, 1'b0, 1'b1},
    '{8'h20, 16'h0000, 2'd0, 1'b1, 1'b1},
    '{8'hf4, 16'h0000, 2'd0, 1'b1, 1'b1},
    '{8'hf3, 16'h0000, 2'd0, 1'b0, 1'b1},
    '{8'hf4, 16'h0001, 2'd2, 1'b0, 1'b0}};
  dsc_if tf ();
  dsc_device #(.ERASE_BLOCKS(8), .ERASE_MINUTES(16'h0007)) dsc_device_inst (
    .clk(clk), .rst(rst), .power_on(power_on), .tf(tf.dev),
    .trk0_reached(trk0_reached), .head_step(head_step), .zero_wr(zero_wr),
    .zero_addr(zero_addr), .id_word89(id_word89), .lock_enabled(lock_enabled),
    .locked(locked), .frozen(frozen));
  dsc_host dsc_host_inst (.clk(clk), .rst(rst), .tf(tf.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  dsc_checker dsc_checker_inst (.clk(clk), .rst(rst), .cmd_wr(tf.cmd_wr),
    .opcode_port(tf.opcode_port), .drive_head_select(tf.drive_head_select),
    .data_wr(tf.data_wr), .data_word(tf.data_word), .error_flags(tf.error_flags),
    .device_status_flags(tf.device_status_flags));
  always #2 clk = ~clk;
  // Head reaches cylinder zero after three steps when allowed
  always @(posedge clk) begin
    if (head_step) steps <= steps + 1;
    trk0_reached <= allow && (steps >= 3);
    if (zero_wr && zero_addr == 32'(blk)) blk <= blk + 1;
  end
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task reg_wr(input logic [3:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
  endtask
  task reg_rd(input logic [3:0] a);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // Load control and password, start, wait for the end, read status
  task run(input logic [7:0] op, input logic [15:0] cw, input logic [1:0] s);
    reg_wr(4'h1, cw);
    for (int i = 0; i < 14; i++) reg_wr(4'(i + 2), {6'h00, s, 8'(i)});
    reg_wr(4'h0, {8'h00, op});
    wr <= 1'b0;
    k = 0;
    @(negedge clk);
    chk(tf.cmd_wr === 1'b1, "command not issued");
    repeat (2) @(negedge clk);
    while ((tf.device_status_flags[7] | tf.device_status_flags[3]) !== 1'b0 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    chk(k < 30000, "command hung");
    @(posedge clk);
    reg_rd(4'h0);
  endtask
  task results;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    results;
  end
  initial begin
    clk = 0; rst = 1; power_on = 1; allow = 0; trk0_reached = 0; wr = 0; rd = 0;
    addr = 0; wdata = 0; steps = 0; blk = 0; n_errors = 0; n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    power_on <= 1'b0;
    @(posedge clk);
    reg_rd(4'h3);
    chk(d === 16'h0050, "reset status");
    $display("reset test done");
    allow <= 1'b1;
    run(8'h1c, 16'h0000, 2'd0);
    chk(d[9] === 1'b0 && steps >= 3, "recalibrate");
    allow <= 1'b0;
    run(8'h10, 16'h0000, 2'd0);
    chk(d[9] === 1'b1 && d[0] === 1'b1, "track zero missing");
    $display("recalibrate tests done");
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].cw, rows[i].sel);
      chk(d[10] === rows[i].ab && d[0] === rows[i].ab, "abort flag");
      chk(lock_enabled === rows[i].le, "lock enable");
    end
    chk(blk == 8, "erase span");
    chk(id_word89 === 16'h0007, "erase time word");
    $display("table tests done");
    run(8'hf1, 16'h0000, 2'd0);
    chk(locked === 1'b0 && lock_enabled === 1'b1, "lock deferred");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(locked === 1'b1, "locked after reset");
    @(posedge clk);
    run(8'hf5, 16'h0000, 2'd0);
    chk(frozen === 1'b1 && d[10] === 1'b0, "freeze");
    foreach (fz[i]) begin
      run(fz[i], 16'h0000, 2'd0);
      chk(d[10] === 1'b1, "frozen reject");
    end
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(frozen === 1'b1, "frozen through reset");
    @(posedge clk);
    power_on <= 1'b1;
    @(posedge clk);
    power_on <= 1'b0;
    @(negedge clk);
    chk(frozen === 1'b0, "power cycle unfreezes");
    chk(locked === 1'b1, "locked after power on");
    $display("freeze tests done");
    results;
  end
endmodule
`default_nettype wire
